// *** rtl/nfpc_defines.svh ***
// Constants for the NAND flash port controller
`ifndef NFPC_DEFINES_SVH
`define NFPC_DEFINES_SVH
`define NFPC_CLK_MHZ        100
`define NFPC_STROBE_NS      30
`define NFPC_STROBE_CYC     ((`NFPC_STROBE_NS * `NFPC_CLK_MHZ + 999) / 1000)
`define NFPC_CMD_READ0      8'h00
`define NFPC_CMD_READ1      8'h30
`define NFPC_CFG_SIG        8'hA5
`define NFPC_CFG_ADDR_BYTES 3'h5
`define NFPC_CFG_LEN        4'h8
`define NFPC_CS_NONE        8'hFF
`define NFPC_CFG_WP_BIT     0
`endif

// *** rtl/nfpc_pkg.sv ***
// Types for the NAND flash port controller
package nfpc_pkg;
  typedef enum logic [9:0] {
    ST_BOOT  = 10'h001,
    ST_PCMD  = 10'h002,
    ST_PADR  = 10'h004,
    ST_PCMD2 = 10'h008,
    ST_PWAIT = 10'h010,
    ST_PRD   = 10'h020,
    ST_IDLE  = 10'h040,
    ST_CMD   = 10'h080,
    ST_ADDR  = 10'h100,
    ST_DATA  = 10'h200
  } nfpc_state_t;

  typedef enum logic [1:0] {
    OP_CMD   = 2'h0,
    OP_ADDR  = 2'h1,
    OP_WRITE = 2'h2,
    OP_READ  = 2'h3
  } nfpc_op_t;
endpackage

// *** rtl/nfpc_top.sv ***
// NAND flash port sequencer: strobes, chip selects, boot probe, protect and indicators
`timescale 1ns/100ps
`include "nfpc_defines.svh"

module nfpc_top #(
  parameter int STROBE_CYC = `NFPC_STROBE_CYC
) (
  input  wire logic        i_mclk,
  input  wire logic        i_srst,
  input  wire logic        i_ce,
  input  wire logic [7:0]  i_dq,
  output logic      [7:0]  o_dq,
  output logic             o_dq_oe,
  input  wire logic [1:0]  i_ready_busy_n,
  output logic             o_write_strobe_n,
  output logic      [1:0]  o_flash_read_strobe_n,
  output logic             o_cmd_latch,
  output logic             o_addr_latch,
  output logic      [7:0]  o_chip_sel_n,
  output logic             o_activity_indicator_n,
  output logic             o_activity_indicator_oe,
  output logic             o_alive_indicator_n,
  output logic             o_alive_indicator_oe,
  output logic             o_flash_protect_out_n,
  output logic             o_flash_protect_out_oe,
  input  wire logic        i_protect_switch_in_n,
  input  wire logic        i_req_valid,
  input  wire nfpc_pkg::nfpc_op_t i_req_op,
  input  wire logic [7:0]  i_req_data,
  input  wire logic [2:0]  i_req_chip,
  input  wire logic        i_req_last,
  input  wire logic        i_cfg_area,
  output logic             o_req_ready,
  output logic             o_rd_valid,
  output logic      [7:0]  o_rd_data,
  output logic             o_req_refused,
  output logic             o_flash_busy,
  output logic             o_media_protected,
  output logic             o_normal_mode,
  output logic             o_mfg_mode,
  output logic             o_cfg_protect_en
);

  initial
  begin
    if (STROBE_CYC < 1 || STROBE_CYC > 255)
      $error("STROBE_CYC out of range");
  end

  typedef struct packed {
    nfpc_pkg::nfpc_state_t st;
    nfpc_pkg::nfpc_op_t    op;
    logic [7:0] cnt;
    logic [2:0] idx;
    logic [2:0] chip;
    logic       last;
    logic       phase;
    logic       in_xfer;
    logic [7:0] dq;
    logic       dq_oe;
    logic       we_n;
    logic [1:0] re_n;
    logic       cle;
    logic       ale;
    logic [7:0] cs_n;
    logic       act_n;
    logic       alive;
    logic       prot;
    logic       ready;
    logic       rd_valid;
    logic [7:0] rd_data;
    logic       refused;
    logic       normal;
    logic       cfg_wp;
    logic [1:0] rb_s1;
    logic [1:0] rb_s2;
    logic       sw_s1;
    logic       sw_s2;
    logic [7:0] dq_s1;
    logic [7:0] dq_s2;
  } nfpc_regs_t;

  nfpc_regs_t cur_ff;
  nfpc_regs_t nxt_ff;

  // One-hot select for a chip index; idle after a last byte selects nothing
  function automatic logic [7:0] sel_n(input logic [2:0] chip);
    sel_n = ~(8'h01 << chip);
  endfunction

  // Ready/busy of the selected chip: odd chips sit on the second line
  function automatic logic chip_ready(input logic [1:0] rb, input logic [2:0] chip);
    chip_ready = rb[chip[0]];
  endfunction

  logic sel_ready;
  logic strobe_done;

  always_comb
  begin
    nxt_ff = cur_ff;
    sel_ready = chip_ready(cur_ff.rb_s2, cur_ff.chip);
    strobe_done = (cur_ff.cnt == 8'(STROBE_CYC - 1));
    nxt_ff.rb_s1 = i_ready_busy_n;
    nxt_ff.rb_s2 = cur_ff.rb_s1;
    nxt_ff.sw_s1 = i_protect_switch_in_n;
    nxt_ff.sw_s2 = cur_ff.sw_s1;
    nxt_ff.dq_s1 = i_dq;
    nxt_ff.dq_s2 = cur_ff.dq_s1;
    nxt_ff.rd_valid = 1'b0;
    nxt_ff.refused = 1'b0;
    nxt_ff.ready = 1'b0;
    // Protect only changes between transfers so a page in flight is never cut
    if (!cur_ff.in_xfer && sel_ready && cur_ff.st != nfpc_pkg::ST_BOOT)
      nxt_ff.prot = ~cur_ff.sw_s2;
    unique case (cur_ff.st)
      nfpc_pkg::ST_BOOT:
      begin
        nxt_ff.chip = 3'h0;
        nxt_ff.cs_n = sel_n(3'h0);
        nxt_ff.dq = `NFPC_CMD_READ0;
        nxt_ff.dq_oe = 1'b1;
        nxt_ff.cle = 1'b1;
        nxt_ff.we_n = 1'b0;
        nxt_ff.cnt = 8'h00;
        nxt_ff.st = nfpc_pkg::ST_PCMD;
      end
      nfpc_pkg::ST_PCMD, nfpc_pkg::ST_PADR, nfpc_pkg::ST_PCMD2:
      begin
        nxt_ff.cnt = cur_ff.cnt + 8'h01;
        if (strobe_done && !cur_ff.phase)
        begin
          nxt_ff.we_n = 1'b1;
          nxt_ff.phase = 1'b1;
          nxt_ff.cnt = 8'h00;
        end
        else if (strobe_done)
        begin
          nxt_ff.phase = 1'b0;
          nxt_ff.cnt = 8'h00;
          nxt_ff.cle = 1'b0;
          nxt_ff.ale = 1'b0;
          if (cur_ff.st == nfpc_pkg::ST_PCMD2)
          begin
            nxt_ff.dq_oe = 1'b0;
            nxt_ff.st = nfpc_pkg::ST_PWAIT;
          end
          else if (cur_ff.st == nfpc_pkg::ST_PCMD ||
                   cur_ff.idx != `NFPC_CFG_ADDR_BYTES - 3'h1)
          begin
            nxt_ff.idx = (cur_ff.st == nfpc_pkg::ST_PCMD) ? 3'h0 : cur_ff.idx + 3'h1;
            nxt_ff.dq = 8'h00;
            nxt_ff.ale = 1'b1;
            nxt_ff.we_n = 1'b0;
            nxt_ff.st = nfpc_pkg::ST_PADR;
          end
          else
          begin
            nxt_ff.dq = `NFPC_CMD_READ1;
            nxt_ff.cle = 1'b1;
            nxt_ff.we_n = 1'b0;
            nxt_ff.st = nfpc_pkg::ST_PCMD2;
          end
        end
      end
      nfpc_pkg::ST_PWAIT:
      begin
        // A missing flash never drops busy; the pull-up reads ready and data floats high
        // Count stops at the end of the settle time so a long busy is not missed
        if (!strobe_done)
          nxt_ff.cnt = cur_ff.cnt + 8'h01;
        if (sel_ready && strobe_done)
        begin
          nxt_ff.cnt = 8'h00;
          nxt_ff.idx = 3'h0;
          nxt_ff.re_n = 2'b00;
          nxt_ff.st = nfpc_pkg::ST_PRD;
        end
      end
      nfpc_pkg::ST_PRD:
      begin
        nxt_ff.cnt = cur_ff.cnt + 8'h01;
        if (strobe_done && !cur_ff.phase)
        begin
          nxt_ff.re_n = 2'b11;
          nxt_ff.phase = 1'b1;
          nxt_ff.cnt = 8'h00;
          if (cur_ff.idx == 3'h0)
            nxt_ff.normal = (cur_ff.dq_s2 == `NFPC_CFG_SIG);
          else if (cur_ff.idx == 3'h1)
            nxt_ff.cfg_wp = cur_ff.dq_s2[`NFPC_CFG_WP_BIT];
        end
        else if (strobe_done)
        begin
          nxt_ff.phase = 1'b0;
          nxt_ff.cnt = 8'h00;
          nxt_ff.idx = cur_ff.idx + 3'h1;
          if (cur_ff.idx == 3'h1 || !cur_ff.normal)
          begin
            if (!cur_ff.normal)
              nxt_ff.cfg_wp = 1'b1;
            nxt_ff.cs_n = `NFPC_CS_NONE;
            nxt_ff.alive = 1'b1;
            nxt_ff.ready = 1'b1;
            nxt_ff.st = nfpc_pkg::ST_IDLE;
          end
          else
            nxt_ff.re_n = 2'b00;
        end
      end
      nfpc_pkg::ST_IDLE:
      begin
        nxt_ff.ready = 1'b1;
        if (i_req_valid)
        begin
          nxt_ff.ready = 1'b0;
          // Config area writes: blocked by switch, or in normal mode once protected
          if (i_req_op == nfpc_pkg::OP_WRITE && i_cfg_area &&
              (cur_ff.prot || (cur_ff.normal && cur_ff.cfg_wp)))
          begin
            nxt_ff.refused = 1'b1;
            nxt_ff.ready = 1'b1;
          end
          else
          begin
            nxt_ff.op = i_req_op;
            nxt_ff.chip = i_req_chip;
            nxt_ff.last = i_req_last;
            nxt_ff.cs_n = sel_n(i_req_chip);
            nxt_ff.cnt = 8'h00;
            nxt_ff.phase = 1'b0;
            nxt_ff.dq = i_req_data;
            nxt_ff.dq_oe = (i_req_op != nfpc_pkg::OP_READ);
            nxt_ff.cle = (i_req_op == nfpc_pkg::OP_CMD);
            nxt_ff.ale = (i_req_op == nfpc_pkg::OP_ADDR);
            if (i_req_op == nfpc_pkg::OP_READ || i_req_op == nfpc_pkg::OP_WRITE)
            begin
              nxt_ff.in_xfer = 1'b1;
              nxt_ff.act_n = 1'b0;
            end
            unique case (i_req_op)
              nfpc_pkg::OP_CMD:  nxt_ff.st = nfpc_pkg::ST_CMD;
              nfpc_pkg::OP_ADDR: nxt_ff.st = nfpc_pkg::ST_ADDR;
              default:           nxt_ff.st = nfpc_pkg::ST_DATA;
            endcase
          end
        end
      end
      nfpc_pkg::ST_CMD, nfpc_pkg::ST_ADDR, nfpc_pkg::ST_DATA:
      begin
        // Reads wait on ready/busy; the low phase is counted from the strobe fall
        nxt_ff.cnt = cur_ff.cnt + 8'h01;
        if (!cur_ff.phase && cur_ff.we_n && cur_ff.re_n == 2'b11)
        begin
          nxt_ff.cnt = 8'h00;
          if (cur_ff.op != nfpc_pkg::OP_READ || sel_ready)
          begin
            if (cur_ff.op == nfpc_pkg::OP_READ)
              nxt_ff.re_n[cur_ff.chip[0]] = 1'b0;
            else
              nxt_ff.we_n = 1'b0;
          end
        end
        else if (strobe_done && !cur_ff.phase)
        begin
          nxt_ff.phase = 1'b1;
          nxt_ff.cnt = 8'h00;
          nxt_ff.we_n = 1'b1;
          nxt_ff.re_n = 2'b11;
          if (cur_ff.op == nfpc_pkg::OP_READ)
          begin
            nxt_ff.rd_data = cur_ff.dq_s2;
            nxt_ff.rd_valid = 1'b1;
          end
        end
        else if (strobe_done)
        begin
          nxt_ff.phase = 1'b0;
          nxt_ff.cle = 1'b0;
          nxt_ff.ale = 1'b0;
          nxt_ff.dq_oe = 1'b0;
          nxt_ff.ready = 1'b1;
          nxt_ff.st = nfpc_pkg::ST_IDLE;
          if (cur_ff.last)
          begin
            nxt_ff.cs_n = `NFPC_CS_NONE;
            nxt_ff.in_xfer = 1'b0;
            nxt_ff.act_n = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      cur_ff <= '0;
      cur_ff.st <= nfpc_pkg::ST_BOOT;
      cur_ff.we_n <= 1'b1;
      cur_ff.re_n <= 2'b11;
      cur_ff.cs_n <= `NFPC_CS_NONE;
      cur_ff.act_n <= 1'b1;
      cur_ff.cfg_wp <= 1'b1;
      cur_ff.rb_s1 <= 2'b11;
      cur_ff.rb_s2 <= 2'b11;
      cur_ff.sw_s1 <= 1'b1;
      cur_ff.sw_s2 <= 1'b1;
    end
    else if (i_ce)
      cur_ff <= nxt_ff;
  end

  assign o_dq = cur_ff.dq;
  assign o_dq_oe = cur_ff.dq_oe;
  assign o_write_strobe_n = cur_ff.we_n;
  assign o_flash_read_strobe_n = cur_ff.re_n;
  assign o_cmd_latch = cur_ff.cle;
  assign o_addr_latch = cur_ff.ale;
  assign o_chip_sel_n = cur_ff.cs_n;
  assign o_activity_indicator_n = 1'b0;
  assign o_activity_indicator_oe = ~cur_ff.act_n;
  assign o_alive_indicator_n = 1'b0;
  assign o_alive_indicator_oe = cur_ff.alive;
  assign o_flash_protect_out_n = 1'b0;
  assign o_flash_protect_out_oe = cur_ff.prot;
  assign o_req_ready = cur_ff.ready;
  assign o_rd_valid = cur_ff.rd_valid;
  assign o_rd_data = cur_ff.rd_data;
  assign o_req_refused = cur_ff.refused;
  assign o_flash_busy = ~chip_ready(cur_ff.rb_s2, cur_ff.chip);
  assign o_media_protected = cur_ff.prot;
  assign o_normal_mode = cur_ff.normal & cur_ff.alive;
  assign o_mfg_mode = ~cur_ff.normal & cur_ff.alive;
  assign o_cfg_protect_en = cur_ff.cfg_wp;

endmodule

// *** verif/nfpc_flash_model.sv ***
// Behavioural NAND flash memory for the port sequencer bench
`timescale 1ns/100ps
module nfpc_flash_model (
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_bus,
  input  wire logic       i_we_n,
  input  wire logic [1:0] i_re_n,
  input  wire logic       i_cle,
  input  wire logic       i_ale,
  input  wire logic [7:0] i_sig,
  input  wire logic [7:0] i_cfg1,
  output logic      [7:0] o_dq,
  output logic      [1:0] o_rb_n,
  output logic      [7:0] o_byte
);
  logic       we_q = 1'b1;
  logic       re_q = 1'b0;
  logic [3:0] col  = 4'h0;
  logic [4:0] busy = 5'h00;
  logic [7:0] hold = 8'h00;
  logic [7:0] val;
  logic       rd;
  assign rd = i_re_n != 2'h3;
  assign val = col == 4'h0 ? i_sig : col == 4'h1 ? i_cfg1 : {4'hC, col};
  // Released bus shows the inverse of the last byte, so a stale sample is caught
  assign o_dq = rd ? (re_q ? hold : val) : ~hold;
  assign o_rb_n = {2{busy == 5'h00}};
  always @(posedge i_mclk)
  begin
    we_q <= i_we_n;
    re_q <= rd;
    if (busy != 5'h00)
      busy <= busy - 5'h01;
    if (i_we_n && !we_q)
    begin
      o_byte <= i_bus;
      if (i_cle || i_ale)
        col <= 4'h0;
      if (i_cle && i_bus == 8'h30)
        busy <= 5'h14;
    end
    if (rd && !re_q)
    begin
      hold <= val;
      col <= col + 4'h1;
    end
  end
endmodule

// *** verif/nfpc_top_sva.sv ***
// Checker for the flash port sequencer pins
`timescale 1ns/100ps
module nfpc_top_sva #(
  parameter int STROBE_CYC = 3
) (
  input wire logic       i_mclk,
  input wire logic       i_srst,
  input wire logic       o_write_strobe_n,
  input wire logic [1:0] o_flash_read_strobe_n,
  input wire logic       o_cmd_latch,
  input wire logic       o_addr_latch,
  input wire logic [7:0] o_chip_sel_n,
  input wire logic       o_activity_indicator_oe,
  input wire logic       o_alive_indicator_oe,
  input wire logic       o_flash_protect_out_oe,
  input wire logic       o_media_protected,
  input wire logic       o_req_refused,
  input wire logic       o_req_ready,
  input wire logic       o_rd_valid,
  input wire logic       o_flash_busy,
  input wire logic       o_normal_mode,
  input wire logic       o_mfg_mode
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  a_cs_onehot: assert property ($onehot0(~o_chip_sel_n))
    else $error("two chip selects low");
  a_strobe_cs: assert property (!o_write_strobe_n |-> o_chip_sel_n != 8'hFF)
    else $error("strobe without chip select");
  a_we_width: assert property ($rose(o_write_strobe_n) |->
    !$past(o_write_strobe_n, STROBE_CYC) && $past(o_write_strobe_n, STROBE_CYC + 1))
    else $error("write strobe width");
  a_cle_hold: assert property (!o_write_strobe_n && o_cmd_latch ##1 o_write_strobe_n |-> o_cmd_latch)
    else $error("command latch dropped");
  a_ale_hold: assert property (!o_write_strobe_n && o_addr_latch ##1 o_write_strobe_n |-> o_addr_latch)
    else $error("address latch dropped");
  a_data_latch: assert property (!o_write_strobe_n && o_activity_indicator_oe |-> !o_cmd_latch && !o_addr_latch)
    else $error("latch on data byte");
  a_rd_rise: assert property (o_rd_valid |-> o_flash_read_strobe_n == 2'h3 && $past(o_flash_read_strobe_n) != 2'h3)
    else $error("read data off strobe rise");
  a_rd_ready: assert property ($fell(o_flash_read_strobe_n[0]) |-> !$past(o_flash_busy))
    else $error("read while busy");
  a_alive_mode: assert property (o_alive_indicator_oe |-> o_normal_mode != o_mfg_mode)
    else $error("alive without mode");
  a_prot_wait: assert property ($rose(o_flash_protect_out_oe) |-> o_media_protected && o_chip_sel_n == 8'hFF)
    else $error("protect during transfer");
  a_refuse_idle: assert property (o_req_refused |-> o_write_strobe_n ##[0:1] o_req_ready)
    else $error("refusal not idle");
  cover property (o_req_refused);
  cover property ($rose(o_flash_protect_out_oe));
  cover property (o_rd_valid && o_normal_mode);
endmodule
bind nfpc_top nfpc_top_sva #(.STROBE_CYC(STROBE_CYC)) u_nfpc_top_sva (
  .i_mclk, .i_srst, .o_write_strobe_n, .o_flash_read_strobe_n, .o_cmd_latch, .o_addr_latch,
  .o_chip_sel_n, .o_activity_indicator_oe, .o_alive_indicator_oe, .o_flash_protect_out_oe,
  .o_media_protected, .o_req_refused, .o_req_ready, .o_rd_valid, .o_flash_busy,
  .o_normal_mode, .o_mfg_mode
);

// *** verif/nand_flash_port_control_bench.sv ***
// Self-checking bench for the flash port sequencer
`timescale 1ns/100ps
module nand_flash_port_control_bench;
  typedef struct packed {
    nfpc_pkg::nfpc_op_t op;
    logic [7:0]         d;
    logic [2:0]         ch;
    logic               l;
    logic [7:0]         cs;
    logic [2:0]         cla;
  } nfpc_row_t;
  logic               i_mclk = 1'b0;
  logic               i_srst = 1'b1;
  logic               vld    = 1'b0;
  logic               ce     = 1'b1;
  nfpc_pkg::nfpc_op_t op     = nfpc_pkg::OP_CMD;
  logic [7:0]         dat    = 8'h00;
  logic [2:0]         chip   = 3'h0;
  logic               lst    = 1'b0;
  logic               cfg    = 1'b0;
  logic               sw_n   = 1'b1;
  logic [7:0]         sig    = 8'hA5;
  logic [7:0]         cfg1   = 8'h00;
  wire  [7:0]         bus, o_dq, m_dq, cs_n, m_byte, rdd;
  wire  [1:0]         re_n, rb_n;
  wire                oe, we_n, cle, ale, act, alive, poe, rdy, rdv, refd, prot, nrm, mfg, cpe;
  int                 num_errors = 0;
  int                 n_checks   = 0;
  int                 cyc        = 0;
  logic [7:0]         s_cs, s_rd;
  logic [2:0]         s_cla;
  logic               s_ref;
  nfpc_row_t          rows [8];
  assign bus = oe ? o_dq : m_dq;
  always #5 i_mclk = ~i_mclk;
  nfpc_top u_nfpc_top (
    .i_mclk, .i_srst, .i_ce(ce), .i_dq(bus), .o_dq, .o_dq_oe(oe), .i_ready_busy_n(rb_n),
    .o_write_strobe_n(we_n), .o_flash_read_strobe_n(re_n), .o_cmd_latch(cle),
    .o_addr_latch(ale), .o_chip_sel_n(cs_n), .o_activity_indicator_n(),
    .o_activity_indicator_oe(act), .o_alive_indicator_n(), .o_alive_indicator_oe(alive),
    .o_flash_protect_out_n(), .o_flash_protect_out_oe(poe), .i_protect_switch_in_n(sw_n),
    .i_req_valid(vld), .i_req_op(op), .i_req_data(dat), .i_req_chip(chip),
    .i_req_last(lst), .i_cfg_area(cfg), .o_req_ready(rdy), .o_rd_valid(rdv),
    .o_rd_data(rdd), .o_req_refused(refd), .o_flash_busy(), .o_media_protected(prot),
    .o_normal_mode(nrm), .o_mfg_mode(mfg), .o_cfg_protect_en(cpe)
  );
  nfpc_flash_model u_nfpc_flash_model (
    .i_mclk, .i_bus(bus), .i_we_n(we_n), .i_re_n(re_n), .i_cle(cle), .i_ale(ale),
    .i_sig(sig), .i_cfg1(cfg1), .o_dq(m_dq), .o_rb_n(rb_n), .o_byte(m_byte)
  );
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic snap;
    if (we_n === 1'b0 || re_n !== 2'h3)
    begin
      s_cs = cs_n;
      s_cla = {cle, ale, act};
    end
    if (rdv === 1'b1)
      s_rd = rdd;
    if (refd === 1'b1)
      s_ref = 1'b1;
  endtask
  task automatic req(input nfpc_pkg::nfpc_op_t o, input logic [7:0] d, input logic [2:0] c,
                     input logic l, input logic a);
    while (rdy !== 1'b1)
      @(posedge i_mclk);
    @(posedge i_mclk);
    op <= o;
    dat <= d;
    chip <= c;
    lst <= l;
    cfg <= a;
    vld <= 1'b1;
    s_ref = 1'b0;
    s_cs = 'x;
    s_rd = 'x;
    @(posedge i_mclk);
    vld <= 1'b0;
    #1;
    snap();
    while (rdy !== 1'b1)
    begin
      @(posedge i_mclk);
      #1;
      snap();
    end
  endtask
  // Reset held a scaled-down time; the boot probe then reads the model's page 0
  task automatic boot(input logic [7:0] s, input logic [7:0] c1);
    @(posedge i_mclk);
    sig <= s;
    cfg1 <= c1;
    i_srst <= 1'b1;
    repeat (5) @(posedge i_mclk);
    #1;
    chk({4'h0, rdy, we_n, alive, poe}, 8'h04);
    chk(cs_n, 8'hFF);
    @(posedge i_mclk);
    i_srst <= 1'b0;
    @(posedge i_mclk);
    while (rdy !== 1'b1)
      @(posedge i_mclk);
    @(posedge i_mclk);
    #1;
  endtask
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      complete_run();
    end
  end
  initial
  begin
    rows = '{'{nfpc_pkg::OP_CMD, 8'h00, 3'h2, 1'b0, 8'hFB, 3'h4},
             '{nfpc_pkg::OP_ADDR, 8'h00, 3'h2, 1'b0, 8'hFB, 3'h2},
             '{nfpc_pkg::OP_CMD, 8'h30, 3'h2, 1'b0, 8'hFB, 3'h4},
             '{nfpc_pkg::OP_READ, 8'hA5, 3'h2, 1'b0, 8'hFB, 3'h1},
             '{nfpc_pkg::OP_READ, 8'h00, 3'h2, 1'b1, 8'hFB, 3'h1},
             '{nfpc_pkg::OP_CMD, 8'h80, 3'h7, 1'b0, 8'h7F, 3'h4},
             '{nfpc_pkg::OP_WRITE, 8'h5A, 3'h7, 1'b0, 8'h7F, 3'h1},
             '{nfpc_pkg::OP_WRITE, 8'hC3, 3'h7, 1'b1, 8'h7F, 3'h1}};
    boot(8'hA5, 8'h00);
    chk({4'h0, nrm, mfg, cpe, alive}, 8'h09);
    foreach (rows[i])
    begin
      req(rows[i].op, rows[i].d, rows[i].ch, rows[i].l, 1'b0);
      chk(s_cs, rows[i].cs);
      chk({5'h00, s_cla}, {5'h00, rows[i].cla});
      if (rows[i].op == nfpc_pkg::OP_READ)
        chk(s_rd, rows[i].d);
      else
        chk(m_byte, rows[i].d);
    end
    chk(cs_n, 8'hFF);
    $display("test rows done");
    req(nfpc_pkg::OP_WRITE, 8'h11, 3'h0, 1'b1, 1'b1);
    chk({7'h00, s_ref}, 8'h00);
    boot(8'hA5, 8'h01);
    chk({7'h00, cpe}, 8'h01);
    req(nfpc_pkg::OP_WRITE, 8'h12, 3'h0, 1'b1, 1'b1);
    chk({7'h00, s_ref}, 8'h01);
    boot(8'h3C, 8'h00);
    chk({4'h0, nrm, mfg, cpe, alive}, 8'h07);
    req(nfpc_pkg::OP_WRITE, 8'h13, 3'h0, 1'b1, 1'b1);
    chk({7'h00, s_ref}, 8'h00);
    $display("test modes done");
    @(posedge i_mclk);
    ce <= 1'b0;
    vld <= 1'b1;
    repeat (6) @(posedge i_mclk);
    #1;
    chk({6'h00, rdy, we_n}, 8'h03);
    @(posedge i_mclk);
    vld <= 1'b0;
    ce <= 1'b1;
    $display("test enable done");
    req(nfpc_pkg::OP_WRITE, 8'h22, 3'h1, 1'b0, 1'b0);
    @(posedge i_mclk);
    sw_n <= 1'b0;
    repeat (10) @(posedge i_mclk);
    #1;
    chk({7'h00, poe}, 8'h00);
    req(nfpc_pkg::OP_WRITE, 8'h33, 3'h1, 1'b1, 1'b0);
    repeat (10) @(posedge i_mclk);
    #1;
    chk({6'h00, poe, prot}, 8'h03);
    req(nfpc_pkg::OP_WRITE, 8'h14, 3'h0, 1'b1, 1'b1);
    chk({7'h00, s_ref}, 8'h01);
    $display("test protect done");
    complete_run();
  end
endmodule
